// >>> design/cmp_pwm_defs.vh
// Constants for the compare trigger and PWM unit: addresses, fields, encodings
`ifndef CMP_PWM_DEFS_VH
`define CMP_PWM_DEFS_VH

// Register byte addresses on the AXI4-Lite bus
`define ADR_U1_CMP_LO 8'h00
`define ADR_U1_CMP_HI 8'h04
`define ADR_U1_CTL 8'h08
`define ADR_U2_CMP_LO 8'h0C
`define ADR_U2_CMP_HI 8'h10
`define ADR_U2_CTL 8'h14
`define ADR_T3_CTL 8'h18
`define ADR_FLAGS 8'h1C
`define ADR_ENABLES 8'h20
`define ADR_PRIORITY 8'h24
`define ADR_PERIOD 8'h28
`define ADR_PERIOD_CTL 8'h2C
`define ADR_PERIOD_TMR 8'h30

// Unit control fields
`define CTL_MODE 3:0
`define CTL_DUTY 5:4
`define CTL_WIDTH 6

// Mode select encodings
`define MODE_TOGGLE 4'h2
`define MODE_DRIVE_HIGH 4'h8
`define MODE_DRIVE_LOW 4'h9
`define MODE_SOFT_INT 4'hA
`define MODE_EVENT_TRIG 4'hB
`define MODE_PWM_TOP 2'h3

// Timer select bits in the third timer's control register
`define T3_SEL_HIGH 6
`define T3_SEL_LOW 3

// Flag, enable and priority bit positions
`define BIT_UNIT_TWO 2
`define BIT_UNIT_ONE 1

// Period timer control fields
`define PCTL_PRESCALE 1:0
`define PCTL_ON 2
`define PCTL_POST 6:3
`define PCTL_WIDTH 7
`define PRE_DIV1 2'h0
`define PRE_DIV4 2'h1

// Reset values and bus answers
`define RST_BYTE 8'h00
`define RST_PERIOD 8'hFF
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define QUARTER_LAST 2'h3

`endif

// >>> design/cmp_pwm_unit.v
// One compare/PWM channel: compare match, event trigger and PWM pin latch
`timescale 1ns/1ps
`default_nettype none
`include "cmp_pwm_defs.vh"

module cmp_pwm_unit #(
  parameter HAS_CONVERSION = 0
) (
  input wire i_clk,
  input wire i_rst_n,
  input wire [`CTL_WIDTH-1:0] i_control,
  input wire i_control_cleared,
  input wire [7:0] i_cmp_low,
  input wire [7:0] i_cmp_high,
  input wire i_use_third,
  input wire [15:0] i_first_timer,
  input wire [15:0] i_third_timer,
  input wire i_adc_enabled,
  input wire i_period_start,
  input wire [9:0] i_fine_count,
  output wire o_pwm_mode,
  output wire [7:0] o_duty_buffer,
  output wire o_pin,
  output wire o_flag_set,
  output wire o_first_reset,
  output wire o_third_reset,
  output wire o_conv_start
);
  wire [3:0] mode = i_control[`CTL_MODE];
  wire pwm_mode = (mode[3:2] == `MODE_PWM_TOP);
  wire compare_mode = (mode[3] && !pwm_mode) || (mode == `MODE_TOGGLE);
  wire event_mode = (mode == `MODE_EVENT_TRIG);
  wire [15:0] time_base = i_use_third ? i_third_timer : i_first_timer;
  wire hit = compare_mode && (time_base == {i_cmp_high, i_cmp_low});
  reg hit_reg;
  wire match = hit && !hit_reg;
  wire [9:0] next_duty = {i_cmp_low, i_control[`CTL_DUTY]};
  reg [7:0] duty_buf_reg;
  reg [1:0] duty_lsb_reg;
  reg pin_reg;
  reg first_reset_reg;
  reg third_reset_reg;
  reg conv_reg;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hit_reg <= 1'b0;
      first_reset_reg <= 1'b0;
      third_reset_reg <= 1'b0;
      conv_reg <= 1'b0;
    end else begin
      hit_reg <= hit;
      first_reset_reg <= match && event_mode && !i_use_third;
      third_reset_reg <= match && event_mode && i_use_third;
      conv_reg <= (HAS_CONVERSION != 0) && match && event_mode && i_adc_enabled;
    end
  end

  // Duty double buffer loads only at a period boundary
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      duty_buf_reg <= `RST_BYTE;
      duty_lsb_reg <= 2'h0;
    end else if (pwm_mode && i_period_start) begin
      duty_buf_reg <= next_duty[9:2];
      duty_lsb_reg <= next_duty[1:0];
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_reg <= 1'b0;
    end else if (i_control_cleared) begin
      pin_reg <= 1'b0;
    end else if (pwm_mode) begin
      if (i_period_start) begin
        pin_reg <= (next_duty != 10'h000);
      end else if (i_fine_count == {duty_buf_reg, duty_lsb_reg}) begin
        pin_reg <= 1'b0;
      end
    end else if (match) begin
      case (mode)
        `MODE_DRIVE_HIGH: pin_reg <= 1'b1;
        `MODE_DRIVE_LOW: pin_reg <= 1'b0;
        `MODE_TOGGLE: pin_reg <= ~pin_reg;
        default: pin_reg <= pin_reg;
      endcase
    end
  end

  assign o_pwm_mode = pwm_mode;
  assign o_duty_buffer = duty_buf_reg;
  assign o_pin = pin_reg;
  assign o_flag_set = match;
  assign o_first_reset = first_reset_reg;
  assign o_third_reset = third_reset_reg;
  assign o_conv_start = conv_reg;
endmodule // cmp_pwm_unit

`default_nettype wire

// >>> design/cmp_pwm_top.v
// Compare event trigger and PWM unit with period timer and AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "cmp_pwm_defs.vh"

// Function
// - Event trigger only in mode 1011
// - Trigger resets the assigned wide timer
// - Unit two trigger starts enabled conversion
// - Unit one trigger never starts conversion
// - PWM mode drives ten-bit duty waveform
// - Zero control write clears output latch
// - Period timer clears after period match
// - Pin set each period unless duty zero
// - Duty low copied to buffer at period end
// - Postscaler affects only timer event rate
// - Duty is low register plus control 5:4
// - New duty applied only after period match
// - Buffer register read-only in PWM mode
// - Duty double-buffered with two-bit latch
// - Pin cleared when duty equals extended timer
// - Duty beyond period keeps pin high
// - Period prescale of one, four, sixteen
// - Compare register matched against selected timer
// - Compare match sets unit flag
// - Timer selection from third timer control
module cmp_pwm_top (
  input wire I_CLOCK,
  input wire I_RESETN,
  input wire [7:0] I_AXI_AWADDR,
  input wire I_AXI_AWVALID,
  output wire O_AXI_AWREADY,
  input wire [31:0] I_AXI_WDATA,
  input wire [3:0] I_AXI_WSTRB,
  input wire I_AXI_WVALID,
  output wire O_AXI_WREADY,
  output wire [1:0] O_AXI_BRESP,
  output wire O_AXI_BVALID,
  input wire I_AXI_BREADY,
  input wire [7:0] I_AXI_ARADDR,
  input wire I_AXI_ARVALID,
  output wire O_AXI_ARREADY,
  output wire [31:0] O_AXI_RDATA,
  output wire [1:0] O_AXI_RRESP,
  output wire O_AXI_RVALID,
  input wire I_AXI_RREADY,
  input wire [15:0] I_FIRST_TIMER,
  input wire [15:0] I_THIRD_TIMER,
  input wire I_ADC_ENABLED,
  output wire O_FIRST_TIMER_RESET,
  output wire O_THIRD_TIMER_RESET,
  output wire O_CONVERSION_START,
  output wire O_UNIT_ONE_PIN,
  output wire O_UNIT_TWO_PIN,
  output wire O_UNIT_ONE_IRQ_FLAG,
  output wire O_UNIT_TWO_IRQ_FLAG,
  output wire O_PERIOD_TIMER_EVENT
);
  reg rst_meta_reg;
  reg rst_sync_reg;
  wire rst_n = rst_sync_reg;

  always @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  // Register file
  reg [7:0] u1_cmp_lo_reg;
  reg [7:0] u1_cmp_hi_reg;
  reg [`CTL_WIDTH-1:0] u1_ctl_reg;
  reg [7:0] u2_cmp_lo_reg;
  reg [7:0] u2_cmp_hi_reg;
  reg [`CTL_WIDTH-1:0] u2_ctl_reg;
  reg [7:0] t3_ctl_reg;
  reg u1_flag_reg;
  reg u2_flag_reg;
  reg u1_enable_reg;
  reg u2_enable_reg;
  reg u1_priority_reg;
  reg u2_priority_reg;
  reg [7:0] period_reg;
  reg [`PCTL_WIDTH-1:0] period_ctl_reg;
  reg [7:0] period_tmr_reg;
  // Bus slave state
  reg aw_full_reg;
  reg [7:0] aw_addr_reg;
  reg w_full_reg;
  reg [31:0] w_data_reg;
  reg w_lane0_reg;
  reg bvalid_reg;
  reg [1:0] bresp_reg;
  reg rvalid_reg;
  reg [31:0] rdata_reg;
  reg [1:0] rresp_reg;

  wire aw_take = I_AXI_AWVALID && O_AXI_AWREADY;
  wire w_take = I_AXI_WVALID && O_AXI_WREADY;
  wire ar_take = I_AXI_ARVALID && O_AXI_ARREADY;
  wire do_write = aw_full_reg && w_full_reg && !bvalid_reg;
  wire wr_en = do_write && w_lane0_reg;
  wire [7:0] wr_byte = w_data_reg[7:0];

  assign O_AXI_AWREADY = !aw_full_reg && !bvalid_reg;
  assign O_AXI_WREADY = !w_full_reg && !bvalid_reg;
  assign O_AXI_ARREADY = !rvalid_reg;
  assign O_AXI_BVALID = bvalid_reg;
  assign O_AXI_BRESP = bresp_reg;
  assign O_AXI_RVALID = rvalid_reg;
  assign O_AXI_RDATA = rdata_reg;
  assign O_AXI_RRESP = rresp_reg;

  function addr_known;
    input [7:0] addr;
    begin
      case (addr)
        `ADR_U1_CMP_LO, `ADR_U1_CMP_HI, `ADR_U1_CTL, `ADR_U2_CMP_LO, `ADR_U2_CMP_HI,
        `ADR_U2_CTL, `ADR_T3_CTL, `ADR_FLAGS, `ADR_ENABLES, `ADR_PRIORITY, `ADR_PERIOD,
        `ADR_PERIOD_CTL, `ADR_PERIOD_TMR: addr_known = 1'b1;
        default: addr_known = 1'b0;
      endcase
    end
  endfunction

  always @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= `RST_BYTE;
      w_full_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_lane0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= I_AXI_AWADDR;
      end
      if (w_take) begin
        w_full_reg <= 1'b1;
        w_data_reg <= I_AXI_WDATA;
        w_lane0_reg <= I_AXI_WSTRB[0];
      end
      if (do_write) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= addr_known(aw_addr_reg) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_reg && I_AXI_BREADY) begin
        bvalid_reg <= 1'b0;
      end
    end
  end
  // Per-unit wiring
  wire u1_pwm;
  wire u2_pwm;
  wire [7:0] u1_duty_buf;
  wire [7:0] u2_duty_buf;
  wire u1_flag_set;
  wire u2_flag_set;
  wire u1_first_rst;
  wire u1_third_rst;
  wire u2_first_rst;
  wire u2_third_rst;
  wire u2_conv;
  wire u1_ctl_zero = wr_en && (aw_addr_reg == `ADR_U1_CTL) && (wr_byte == `RST_BYTE);
  wire u2_ctl_zero = wr_en && (aw_addr_reg == `ADR_U2_CTL) && (wr_byte == `RST_BYTE);
  wire u1_use_third = t3_ctl_reg[`T3_SEL_HIGH];
  wire u2_use_third = t3_ctl_reg[`T3_SEL_HIGH] || t3_ctl_reg[`T3_SEL_LOW];
  // Register writes
  always @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      u1_cmp_lo_reg <= `RST_BYTE;
      u1_cmp_hi_reg <= `RST_BYTE;
      u1_ctl_reg <= {`CTL_WIDTH{1'b0}};
      u2_cmp_lo_reg <= `RST_BYTE;
      u2_cmp_hi_reg <= `RST_BYTE;
      u2_ctl_reg <= {`CTL_WIDTH{1'b0}};
      t3_ctl_reg <= `RST_BYTE;
      u1_enable_reg <= 1'b0;
      u2_enable_reg <= 1'b0;
      u1_priority_reg <= 1'b0;
      u2_priority_reg <= 1'b0;
      period_reg <= `RST_PERIOD;
      period_ctl_reg <= {`PCTL_WIDTH{1'b0}};
    end else if (wr_en) begin
      case (aw_addr_reg)
        `ADR_U1_CMP_LO: u1_cmp_lo_reg <= wr_byte;
        `ADR_U1_CMP_HI: if (!u1_pwm) u1_cmp_hi_reg <= wr_byte;
        `ADR_U1_CTL: u1_ctl_reg <= wr_byte[`CTL_WIDTH-1:0];
        `ADR_U2_CMP_LO: u2_cmp_lo_reg <= wr_byte;
        `ADR_U2_CMP_HI: if (!u2_pwm) u2_cmp_hi_reg <= wr_byte;
        `ADR_U2_CTL: u2_ctl_reg <= wr_byte[`CTL_WIDTH-1:0];
        `ADR_T3_CTL: t3_ctl_reg <= wr_byte;
        `ADR_ENABLES: begin
          u1_enable_reg <= wr_byte[`BIT_UNIT_ONE];
          u2_enable_reg <= wr_byte[`BIT_UNIT_TWO];
        end
        `ADR_PRIORITY: begin
          u1_priority_reg <= wr_byte[`BIT_UNIT_ONE];
          u2_priority_reg <= wr_byte[`BIT_UNIT_TWO];
        end
        `ADR_PERIOD: period_reg <= wr_byte;
        `ADR_PERIOD_CTL: period_ctl_reg <= wr_byte[`PCTL_WIDTH-1:0];
        default: period_reg <= period_reg;
      endcase
    end
  end
  // Flags: a hardware set in the same cycle as a software write wins
  wire flag_wr = wr_en && (aw_addr_reg == `ADR_FLAGS);
  always @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      u1_flag_reg <= 1'b0;
      u2_flag_reg <= 1'b0;
    end else begin
      if (u1_flag_set) begin
        u1_flag_reg <= 1'b1;
      end else if (flag_wr) begin
        u1_flag_reg <= wr_byte[`BIT_UNIT_ONE];
      end
      if (u2_flag_set) begin
        u2_flag_reg <= 1'b1;
      end else if (flag_wr) begin
        u2_flag_reg <= wr_byte[`BIT_UNIT_TWO];
      end
    end
  end
  // Period timer: quarter-cycle counter, prescaler and 8-bit count
  reg [1:0] quarter_reg;
  reg [3:0] prescale_reg;
  reg [3:0] post_reg;
  reg post_event_reg;
  wire [1:0] ps_sel = period_ctl_reg[`PCTL_PRESCALE];
  wire timer_on = period_ctl_reg[`PCTL_ON];
  reg pre_done;
  reg [1:0] fine_low;

  always @* begin
    case (ps_sel)
      `PRE_DIV1: begin
        pre_done = 1'b1;
        fine_low = quarter_reg;
      end
      `PRE_DIV4: begin
        pre_done = (prescale_reg[1:0] == 2'h3);
        fine_low = prescale_reg[1:0];
      end
      default: begin
        pre_done = (prescale_reg == 4'hF);
        fine_low = prescale_reg[3:2];
      end
    endcase
  end

  wire tick = timer_on && (quarter_reg == `QUARTER_LAST) && pre_done;
  wire period_start = tick && (period_tmr_reg == period_reg);
  wire tmr_wr = wr_en && (aw_addr_reg == `ADR_PERIOD_TMR);
  wire [9:0] fine_count = {period_tmr_reg, fine_low};

  always @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      quarter_reg <= 2'h0;
      prescale_reg <= 4'h0;
      period_tmr_reg <= `RST_BYTE;
      post_reg <= 4'h0;
      post_event_reg <= 1'b0;
    end else begin
      quarter_reg <= quarter_reg + 2'h1;
      post_event_reg <= 1'b0;
      if (timer_on && (quarter_reg == `QUARTER_LAST)) begin
        prescale_reg <= pre_done ? 4'h0 : prescale_reg + 4'h1;
      end
      if (tmr_wr) begin
        period_tmr_reg <= wr_byte;
        prescale_reg <= 4'h0;
        post_reg <= 4'h0;
      end else if (period_start) begin
        period_tmr_reg <= `RST_BYTE;
        if (post_reg == period_ctl_reg[`PCTL_POST]) begin
          post_reg <= 4'h0;
          post_event_reg <= 1'b1;
        end else begin
          post_reg <= post_reg + 4'h1;
        end
      end else if (tick) begin
        period_tmr_reg <= period_tmr_reg + 8'h01;
      end
    end
  end

  cmp_pwm_unit #(
    .HAS_CONVERSION(0)
  ) unit_one_inst (
    .i_clk(I_CLOCK), .i_rst_n(rst_n), .i_control(u1_ctl_reg),
    .i_control_cleared(u1_ctl_zero), .i_cmp_low(u1_cmp_lo_reg), .i_cmp_high(u1_cmp_hi_reg),
    .i_use_third(u1_use_third), .i_first_timer(I_FIRST_TIMER), .i_third_timer(I_THIRD_TIMER),
    .i_adc_enabled(I_ADC_ENABLED), .i_period_start(period_start), .i_fine_count(fine_count),
    .o_pwm_mode(u1_pwm), .o_duty_buffer(u1_duty_buf), .o_pin(O_UNIT_ONE_PIN),
    .o_flag_set(u1_flag_set), .o_first_reset(u1_first_rst), .o_third_reset(u1_third_rst),
    .o_conv_start()
  );

  cmp_pwm_unit #(
    .HAS_CONVERSION(1)
  ) unit_two_inst (
    .i_clk(I_CLOCK), .i_rst_n(rst_n), .i_control(u2_ctl_reg),
    .i_control_cleared(u2_ctl_zero), .i_cmp_low(u2_cmp_lo_reg), .i_cmp_high(u2_cmp_hi_reg),
    .i_use_third(u2_use_third), .i_first_timer(I_FIRST_TIMER), .i_third_timer(I_THIRD_TIMER),
    .i_adc_enabled(I_ADC_ENABLED), .i_period_start(period_start), .i_fine_count(fine_count),
    .o_pwm_mode(u2_pwm), .o_duty_buffer(u2_duty_buf), .o_pin(O_UNIT_TWO_PIN),
    .o_flag_set(u2_flag_set), .o_first_reset(u2_first_rst), .o_third_reset(u2_third_rst),
    .o_conv_start(u2_conv)
  );

  assign O_FIRST_TIMER_RESET = u1_first_rst || u2_first_rst;
  assign O_THIRD_TIMER_RESET = u1_third_rst || u2_third_rst;
  assign O_CONVERSION_START = u2_conv;
  assign O_UNIT_ONE_IRQ_FLAG = u1_flag_reg;
  assign O_UNIT_TWO_IRQ_FLAG = u2_flag_reg;
  assign O_PERIOD_TIMER_EVENT = post_event_reg;
  // Read path
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = `RST_BYTE;
    case (I_AXI_ARADDR)
      `ADR_U1_CMP_LO: rd_byte = u1_cmp_lo_reg;
      `ADR_U1_CMP_HI: rd_byte = u1_pwm ? u1_duty_buf : u1_cmp_hi_reg;
      `ADR_U1_CTL: rd_byte = {2'h0, u1_ctl_reg};
      `ADR_U2_CMP_LO: rd_byte = u2_cmp_lo_reg;
      `ADR_U2_CMP_HI: rd_byte = u2_pwm ? u2_duty_buf : u2_cmp_hi_reg;
      `ADR_U2_CTL: rd_byte = {2'h0, u2_ctl_reg};
      `ADR_T3_CTL: rd_byte = t3_ctl_reg;
      `ADR_FLAGS: rd_byte = {5'h00, u2_flag_reg, u1_flag_reg, 1'b0};
      `ADR_ENABLES: rd_byte = {5'h00, u2_enable_reg, u1_enable_reg, 1'b0};
      `ADR_PRIORITY: rd_byte = {5'h00, u2_priority_reg, u1_priority_reg, 1'b0};
      `ADR_PERIOD: rd_byte = period_reg;
      `ADR_PERIOD_CTL: rd_byte = {1'b0, period_ctl_reg};
      `ADR_PERIOD_TMR: rd_byte = period_tmr_reg;
      default: rd_byte = `RST_BYTE;
    endcase
  end

  always @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {24'h000000, rd_byte};
      rresp_reg <= addr_known(I_AXI_ARADDR) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_reg && I_AXI_RREADY) begin
      rvalid_reg <= 1'b0;
    end
  end
endmodule // cmp_pwm_top

`default_nettype wire

// >>> tb/cmp_pwm_monitor.sv
// Checker of bus handshakes, trigger pulses and flags at the unit's ports
`timescale 1ns/1ps
`default_nettype none
module cmp_pwm_monitor (
  input wire logic I_CLOCK,
  input wire logic I_RESETN,
  input wire logic [7:0] I_AXI_AWADDR,
  input wire logic I_AXI_AWVALID,
  input wire logic O_AXI_AWREADY,
  input wire logic [31:0] I_AXI_WDATA,
  input wire logic [3:0] I_AXI_WSTRB,
  input wire logic I_AXI_WVALID,
  input wire logic O_AXI_WREADY,
  input wire logic [1:0] O_AXI_BRESP,
  input wire logic O_AXI_BVALID,
  input wire logic I_AXI_BREADY,
  input wire logic [7:0] I_AXI_ARADDR,
  input wire logic I_AXI_ARVALID,
  input wire logic O_AXI_ARREADY,
  input wire logic [31:0] O_AXI_RDATA,
  input wire logic [1:0] O_AXI_RRESP,
  input wire logic O_AXI_RVALID,
  input wire logic I_AXI_RREADY,
  input wire logic [15:0] I_FIRST_TIMER,
  input wire logic [15:0] I_THIRD_TIMER,
  input wire logic I_ADC_ENABLED,
  input wire logic O_FIRST_TIMER_RESET,
  input wire logic O_THIRD_TIMER_RESET,
  input wire logic O_CONVERSION_START,
  input wire logic O_UNIT_ONE_PIN,
  input wire logic O_UNIT_TWO_PIN,
  input wire logic O_UNIT_ONE_IRQ_FLAG,
  input wire logic O_UNIT_TWO_IRQ_FLAG,
  input wire logic O_PERIOD_TIMER_EVENT
);
  default clocking mon_cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_RESETN);

  sequence s_write_taken;
    I_AXI_AWVALID && O_AXI_AWREADY && I_AXI_WVALID && O_AXI_WREADY;
  endsequence
  sequence s_read_taken;
    I_AXI_ARVALID && O_AXI_ARREADY;
  endsequence
  sequence s_trigger;
    O_FIRST_TIMER_RESET || O_THIRD_TIMER_RESET;
  endsequence

  chk_write_answer: assert property (s_write_taken |-> ##2 O_AXI_BVALID)
    else $error("write response not two cycles after address and data");
  chk_read_answer: assert property (s_read_taken |=> O_AXI_RVALID)
    else $error("read data not one cycle after address");
  chk_bresp_hold: assert property (O_AXI_BVALID && !I_AXI_BREADY |=>
      O_AXI_BVALID && $stable(O_AXI_BRESP))
    else $error("write response dropped before taken");
  chk_rdata_hold: assert property (O_AXI_RVALID && !I_AXI_RREADY |=>
      O_AXI_RVALID && $stable(O_AXI_RDATA))
    else $error("read data dropped before taken");
  chk_first_pulse_one: assert property (O_FIRST_TIMER_RESET |=> !O_FIRST_TIMER_RESET)
    else $error("first timer reset longer than one cycle");
  chk_third_pulse_one: assert property (O_THIRD_TIMER_RESET |=> !O_THIRD_TIMER_RESET)
    else $error("third timer reset longer than one cycle");
  chk_conv_single: assert property (O_CONVERSION_START |=> !O_CONVERSION_START)
    else $error("conversion start longer than one cycle");
  chk_conv_with_reset: assert property (O_CONVERSION_START |-> s_trigger)
    else $error("conversion start without timer reset");
  chk_conv_needs_adc: assert property (O_CONVERSION_START |-> $past(I_ADC_ENABLED))
    else $error("conversion started while converter disabled");
  chk_trigger_flag: assert property (s_trigger |-> O_UNIT_ONE_IRQ_FLAG || O_UNIT_TWO_IRQ_FLAG)
    else $error("trigger without unit flag");
  chk_flag_sticky: assert property ($fell(O_UNIT_ONE_IRQ_FLAG) |->
      $past((I_AXI_WVALID && O_AXI_WREADY) || (I_AXI_AWVALID && O_AXI_AWREADY), 2))
    else $error("unit one flag cleared without a bus write");
endmodule // cmp_pwm_monitor
`default_nettype wire

// >>> tb/test_cmp_pwm_top.sv
// Self-checking bench for the compare trigger and PWM unit
`timescale 1ns/1ps
`default_nettype none
`include "cmp_pwm_defs.vh"
module test_cmp_pwm_top;
  // Row fields: unit, mode, timer select, converter on, first/third/conversion pulses, pin
  typedef struct packed {
    logic [3:0] u;
    logic [3:0] m;
    logic [7:0] t3;
    logic [3:0] a;
    logic [3:0] f1;
    logic [3:0] f3;
    logic [3:0] cv;
    logic [3:0] p;
  } row_t;
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, adc;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rv;
  logic [15:0] first_wide_timer, third_wide_timer;
  logic [1:0] resp;
  wire logic awready, wready, bvalid, arready, rvalid;
  wire logic first_rst, third_rst, conv, pin1, pin2, flag1, flag2, pev;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  int err_total, n_compared, a;
  row_t rows [0:10] = '{36'h0_8_00_1_000_1, 36'h0_9_00_1_000_0, 36'h0_2_00_1_000_1,
    36'h0_A_00_1_000_0, 36'h0_B_00_1_100_0, 36'h0_B_40_1_010_0, 36'h0_B_08_1_100_0,
    36'h1_B_00_1_101_0, 36'h1_B_08_0_010_0, 36'h1_B_40_1_011_0, 36'h1_2_00_1_000_1};

  cmp_pwm_top cmp_pwm_top_inst (
    .I_CLOCK(clk), .I_RESETN(rst_n), .I_AXI_AWADDR(awaddr), .I_AXI_AWVALID(awvalid),
    .O_AXI_AWREADY(awready), .I_AXI_WDATA(wdata), .I_AXI_WSTRB(4'hF), .I_AXI_WVALID(wvalid),
    .O_AXI_WREADY(wready), .O_AXI_BRESP(bresp), .O_AXI_BVALID(bvalid), .I_AXI_BREADY(bready),
    .I_AXI_ARADDR(araddr), .I_AXI_ARVALID(arvalid), .O_AXI_ARREADY(arready),
    .O_AXI_RDATA(rdata), .O_AXI_RRESP(rresp), .O_AXI_RVALID(rvalid), .I_AXI_RREADY(rready),
    .I_FIRST_TIMER(first_wide_timer), .I_THIRD_TIMER(third_wide_timer), .I_ADC_ENABLED(adc),
    .O_FIRST_TIMER_RESET(first_rst), .O_THIRD_TIMER_RESET(third_rst),
    .O_CONVERSION_START(conv), .O_UNIT_ONE_PIN(pin1), .O_UNIT_TWO_PIN(pin2),
    .O_UNIT_ONE_IRQ_FLAG(flag1), .O_UNIT_TWO_IRQ_FLAG(flag2), .O_PERIOD_TIMER_EVENT(pev)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task wr(input logic [7:0] ad, input logic [7:0] d);
    int n;
    @(posedge clk);
    awaddr <= ad;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready) && n < 40);
    resp = bresp;
    bready <= 1'b0;
    if (n >= 40) begin
      err_total++;
      finish_test();
    end
  endtask

  task rd(input logic [7:0] ad);
    int n;
    @(posedge clk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready) && n < 40);
    rv = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (n >= 40) begin
      err_total++;
      finish_test();
    end
  endtask

  // Arms one unit in a compare mode, lets both timers hit the compare value once
  task run_row(input row_t r);
    int c1, c3, cv;
    c1 = 0;
    c3 = 0;
    cv = 0;
    wr(`ADR_T3_CTL, r.t3);
    wr(`ADR_U1_CTL, 8'h00);
    wr(`ADR_U2_CTL, 8'h00);
    wr(`ADR_FLAGS, 8'h00);
    wr(r.u[0] ? `ADR_U2_CTL : `ADR_U1_CTL, {4'h0, r.m});
    adc <= r.a[0];
    first_wide_timer <= 16'h1234;
    third_wide_timer <= 16'h1234;
    repeat (6) begin
      @(posedge clk);
      c1 += first_rst;
      c3 += third_rst;
      cv += conv;
    end
    check("first reset pulses", c1, r.f1);
    check("third reset pulses", c3, r.f3);
    check("conversion pulses", cv, r.cv);
    check("compare pin", r.u[0] ? pin2 : pin1, r.p);
    check("unit flags", {flag2, flag1}, r.u[0] ? 2'h2 : 2'h1);
    first_wide_timer <= 16'h0000;
    third_wide_timer <= 16'h0000;
  endtask

  task run_pwm(input logic [7:0] pr, input logic [1:0] pre, input logic [3:0] post,
      input logic [9:0] duty);
    int ratio, per, hi, ev, want;
    ratio = pre[1] ? 16 : (pre[0] ? 4 : 1);
    per = (pr + 1) * 4 * ratio;
    // Registered pin falls one clock after the fine count reaches the duty
    want = duty == 0 ? 0 : (duty * ratio < per ? duty * ratio + 1 : per);
    hi = 0;
    ev = 0;
    wr(`ADR_PERIOD_CTL, 8'h00);
    wr(`ADR_PERIOD, pr);
    wr(`ADR_PERIOD_TMR, 8'h00);
    wr(`ADR_U1_CMP_LO, duty[9:2]);
    wr(`ADR_U1_CTL, {2'h0, duty[1:0], 4'hC});
    wr(`ADR_PERIOD_CTL, {1'h0, post, 1'h1, pre});
    repeat (2 * per) @(posedge clk);
    wr(`ADR_U1_CMP_HI, 8'h55);
    rd(`ADR_U1_CMP_HI);
    check("duty buffer", rv, {24'h0, duty[9:2]});
    repeat (10 * per) begin
      @(posedge clk);
      hi += pin1;
      ev += pev;
    end
    check("high cycles", hi, 10 * want);
    check("timer events", ev, 10 / (post + 1));
  endtask

  initial begin
    rst_n = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    adc = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    first_wide_timer = 16'h0000;
    third_wide_timer = 16'h0000;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (a = 0; a <= 8'h30; a += 4) begin
      rd(a[7:0]);
      check("reset value", rv, a == `ADR_PERIOD ? 32'hFF : 32'h0);
    end
    wr(8'h34, 8'h5A);
    check("unmapped write", resp, `RESP_SLVERR);
    rd(8'h34);
    check("unmapped read", resp, `RESP_SLVERR);
    wr(`ADR_U1_CMP_LO, 8'h34);
    wr(`ADR_U1_CMP_HI, 8'h12);
    wr(`ADR_U2_CMP_LO, 8'h34);
    wr(`ADR_U2_CMP_HI, 8'h12);
    rd(`ADR_U2_CMP_HI);
    check("compare high", rv, 32'h12);
    for (a = 0; a < 11; a++) begin
      run_row(rows[a]);
    end
    run_pwm(8'h03, 2'h0, 4'h0, 10'h006);
    run_pwm(8'h03, 2'h0, 4'h1, 10'h000);
    run_pwm(8'h03, 2'h0, 4'h0, 10'h00F);
    run_pwm(8'h01, 2'h1, 4'h4, 10'h005);
    run_pwm(8'h00, 2'h3, 4'h0, 10'h003);
    run_pwm(8'h03, 2'h0, 4'h0, 10'h3FF);
    // Long period restarted from zero, so no match can land during the next accesses
    wr(`ADR_PERIOD_CTL, 8'h00);
    wr(`ADR_PERIOD, 8'hFF);
    wr(`ADR_PERIOD_TMR, 8'h00);
    wr(`ADR_PERIOD_CTL, 8'h07);
    wr(`ADR_U1_CMP_LO, 8'h80);
    rd(`ADR_U1_CMP_HI);
    check("buffer before match", rv, 32'hFF);
    check("pin over long duty", pin1, 1'h1);
    wr(`ADR_U1_CTL, 8'h00);
    repeat (2) @(posedge clk);
    check("pin after clear", pin1, 1'h0);
    rd(`ADR_U1_CMP_HI);
    check("compare high kept", rv, 32'h12);
    finish_test();
  end
endmodule // test_cmp_pwm_top

bind cmp_pwm_top cmp_pwm_monitor cmp_pwm_monitor_inst (
  .I_CLOCK(I_CLOCK), .I_RESETN(I_RESETN), .I_AXI_AWADDR(I_AXI_AWADDR),
  .I_AXI_AWVALID(I_AXI_AWVALID), .O_AXI_AWREADY(O_AXI_AWREADY), .I_AXI_WDATA(I_AXI_WDATA),
  .I_AXI_WSTRB(I_AXI_WSTRB), .I_AXI_WVALID(I_AXI_WVALID), .O_AXI_WREADY(O_AXI_WREADY),
  .O_AXI_BRESP(O_AXI_BRESP), .O_AXI_BVALID(O_AXI_BVALID), .I_AXI_BREADY(I_AXI_BREADY),
  .I_AXI_ARADDR(I_AXI_ARADDR), .I_AXI_ARVALID(I_AXI_ARVALID), .O_AXI_ARREADY(O_AXI_ARREADY),
  .O_AXI_RDATA(O_AXI_RDATA), .O_AXI_RRESP(O_AXI_RRESP), .O_AXI_RVALID(O_AXI_RVALID),
  .I_AXI_RREADY(I_AXI_RREADY), .I_FIRST_TIMER(I_FIRST_TIMER), .I_THIRD_TIMER(I_THIRD_TIMER),
  .I_ADC_ENABLED(I_ADC_ENABLED), .O_FIRST_TIMER_RESET(O_FIRST_TIMER_RESET),
  .O_THIRD_TIMER_RESET(O_THIRD_TIMER_RESET), .O_CONVERSION_START(O_CONVERSION_START),
  .O_UNIT_ONE_PIN(O_UNIT_ONE_PIN), .O_UNIT_TWO_PIN(O_UNIT_TWO_PIN),
  .O_UNIT_ONE_IRQ_FLAG(O_UNIT_ONE_IRQ_FLAG), .O_UNIT_TWO_IRQ_FLAG(O_UNIT_TWO_IRQ_FLAG),
  .O_PERIOD_TIMER_EVENT(O_PERIOD_TIMER_EVENT)
);
`default_nettype wire
